// ===== spiq_pkg.sv
package spiq_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int SPIQ_DATA_W = 8;
  localparam int SPIQ_FIFO_DEPTH = 32;
  localparam int SPIQ_SYNC_W = 4;
  localparam logic [3:0] SPIQ_BITS = 4'h8;

  // ----------------------------------------------------------------
  // master half-period in bus cycles per rate select
  // ----------------------------------------------------------------
  localparam logic [6:0] SPIQ_HALF_DIV2 = 7'h01;
  localparam logic [6:0] SPIQ_HALF_DIV8 = 7'h04;
  localparam logic [6:0] SPIQ_HALF_DIV32 = 7'h10;
  localparam logic [6:0] SPIQ_HALF_DIV128 = 7'h40;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic receive_irq_enable;
    logic master_select;
    logic cpol;
    logic cpha;
    logic wired_or_mode;
    logic module_enable;
    logic transmit_irq_enable;
  } spiq_ctrl_t;

  typedef struct packed {
    logic error_irq_enable;
    logic mode_fault_detect_enable;
    logic rate_select_hi;
    logic rate_select_lo;
  } spiq_sctrl_t;

  typedef struct packed {
    logic receive_full_flag;
    logic overflow_flag;
    logic mode_fault_flag;
    logic transmit_empty_flag;
  } spiq_status_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } spiq_pin_t;

  typedef enum logic {
    SPIQ_IDLE = 1'b0,
    SPIQ_XFER = 1'b1
  } spiq_xfer_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam spiq_ctrl_t SPIQ_CTRL_RST = 7'h28;
  localparam spiq_sctrl_t SPIQ_SCTRL_RST = 4'h0;
  localparam spiq_status_t SPIQ_STATUS_RST = 4'h1;
  localparam spiq_pin_t SPIQ_PIN_OFF = 2'h1;

endpackage

// ===== spiq_slave_model.sv
`timescale 1ns/1ns
// external slave, cpol 0 cpha 1, replies with i_tx high byte then low byte
module spiq_slave_model (
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_sel,
  input wire logic [15:0] i_tx,
  output logic o_miso,
  output logic [15:0] o_rx
);
  logic [7:0] sh = 8'h00;
  logic mosi_s = 1'b1;
  logic odd = 1'b0;
  int n = 0;
  initial
  begin
    o_miso = 1'b1;
    o_rx = 16'h0000;
  end
  always @(posedge i_sclk)
  begin
    if (i_sel)
    begin
      if (n == 0)
        sh = odd ? i_tx[7:0] : i_tx[15:8];
      o_miso = sh[7];
    end
  end
  // data is taken 160 ns into the high phase, clear of the master's change at the rising edge
  always @(posedge i_sclk)
  begin
    #160;
    mosi_s = i_mosi;
  end
  // after the eighth bit the line is let go, inverted, once hold has passed
  always @(negedge i_sclk)
  begin
    if (i_sel)
    begin
      sh = {sh[6:0], mosi_s};
      n = n + 1;
      if (n == 8)
      begin
        n = 0;
        odd = ~odd;
        o_rx = {o_rx[7:0], sh};
        o_miso <= #200 ~o_miso;
      end
    end
  end
endmodule

// ===== spiq_top.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module spiq_sync3 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } spiq_sync_t;

  spiq_sync_t r;
  spiq_sync_t n;

  always_comb
  begin
    n = r;
    n.s1 = i_d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int k = 0; k < W; k++)
    begin
      if (r.s2[k] == r.s3[k])
      begin
        n.q[k] = r.s3[k];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign o_q = r.q;
endmodule

// ----------------------------------------------------------------
// receive fifo
// ----------------------------------------------------------------
module spiq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_s_valid,
  output logic o_s_ready,
  input wire logic [WIDTH-1:0] i_s_data,
  output logic o_m_valid,
  input wire logic i_m_ready,
  output logic [WIDTH-1:0] o_m_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } spiq_fptr_t;

  spiq_fptr_t r;
  spiq_fptr_t n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;

  assign empty = (r.wp == r.rp);
  assign full = (r.wp[AW-1:0] == r.rp[AW-1:0]) && (r.wp[AW] != r.rp[AW]);
  assign o_s_ready = !full;
  assign o_m_valid = !empty;
  assign o_m_data = mem[r.rp[AW-1:0]];

  always_comb
  begin
    n = r;
    if (i_s_valid && !full)
    begin
      n.wp = r.wp + 1'b1;
    end
    if (i_m_ready && !empty)
    begin
      n.rp = r.rp + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_s_valid && !full)
    begin
      mem[r.wp[AW-1:0]] <= i_s_data;
    end
  end
endmodule

// ----------------------------------------------------------------
// serial controller top
// ----------------------------------------------------------------
module spiq_top (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ctrl_wr,
  input wire spiq_pkg::spiq_ctrl_t i_ctrl_wdata,
  input wire logic i_sctrl_wr,
  input wire spiq_pkg::spiq_sctrl_t i_sctrl_wdata,
  input wire logic i_status_rd,
  input wire logic i_data_rd,
  input wire logic i_data_wr,
  input wire logic [spiq_pkg::SPIQ_DATA_W-1:0] i_data_wdata,
  input wire logic i_wait,
  input wire logic i_stop,
  input wire logic i_break,
  input wire logic i_break_clear_enable,
  input wire logic i_sclk_pin,
  input wire logic i_ss_n_pin,
  input wire logic i_mosi_pin,
  input wire logic i_miso_pin,
  output spiq_pkg::spiq_ctrl_t o_ctrl,
  output spiq_pkg::spiq_sctrl_t o_sctrl,
  output spiq_pkg::spiq_status_t o_status,
  output logic [spiq_pkg::SPIQ_DATA_W-1:0] o_rx_data,
  output logic o_tx_irq,
  output logic o_rx_irq,
  output logic o_wake,
  output logic o_spi_owns_pins,
  output spiq_pkg::spiq_pin_t o_sclk,
  output spiq_pkg::spiq_pin_t o_mosi,
  output spiq_pkg::spiq_pin_t o_miso
);
  import spiq_pkg::*;

  typedef struct packed {
    spiq_ctrl_t ctrl;
    spiq_sctrl_t sctrl;
    spiq_status_t st;
    logic rf_arm;
    logic ovf_arm;
    logic mf_arm;
    logic [SPIQ_DATA_W-1:0] tx_hold;
    logic tx_full;
    logic [SPIQ_DATA_W-1:0] shift;
    logic sbit;
    logic pend;
    logic [3:0] bitcnt;
    logic [6:0] div;
    logic sclk_o;
    spiq_xfer_t xfer;
    logic [SPIQ_DATA_W-1:0] rx_data;
    logic sclk_d;
    logic ss_d;
    spiq_pin_t sclk;
    spiq_pin_t mosi;
    spiq_pin_t miso;
    logic owns;
    logic tx_irq;
    logic rx_irq;
    logic wake;
  } spiq_state_t;

  localparam spiq_state_t ST_RST = '{
    ctrl: SPIQ_CTRL_RST, sctrl: SPIQ_SCTRL_RST, st: SPIQ_STATUS_RST,
    xfer: SPIQ_IDLE, ss_d: 1'b1, sclk: SPIQ_PIN_OFF, mosi: SPIQ_PIN_OFF,
    miso: SPIQ_PIN_OFF, default: '0};

  spiq_state_t r;
  spiq_state_t n;
  logic [SPIQ_SYNC_W-1:0] sy;
  logic sy_sclk;
  logic sy_ss;
  logic sy_mosi;
  logic sy_miso;
  logic fifo_s_valid;
  logic fifo_s_ready;
  logic [SPIQ_DATA_W-1:0] fifo_s_data;
  logic fifo_m_valid;
  logic fifo_m_ready;
  logic [SPIQ_DATA_W-1:0] fifo_m_data;
  logic acc;
  logic frz;
  logic ms;
  logic en;
  logic lead_e;
  logic trail_e;
  logic chg;
  logic mfc;
  logic [6:0] half;

  // ----------------------------------------------------------------
  // pin synchronisers and receive buffer
  // ----------------------------------------------------------------
  spiq_sync3 #(.W(SPIQ_SYNC_W)) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d({i_miso_pin, i_mosi_pin, !i_ss_n_pin, i_sclk_pin}),
    .o_q(sy)
  );

  assign sy_sclk = sy[0];
  // select travels inverted so a cleared synchroniser reads as deselected
  assign sy_ss = !sy[1];
  assign sy_mosi = sy[2];
  assign sy_miso = sy[3];
  assign fifo_m_ready = !r.st.receive_full_flag && !i_stop;

  spiq_fifo #(.WIDTH(SPIQ_DATA_W), .DEPTH(SPIQ_FIFO_DEPTH)) u_rx_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_s_valid(fifo_s_valid),
    .o_s_ready(fifo_s_ready),
    .i_s_data(fifo_s_data),
    .o_m_valid(fifo_m_valid),
    .i_m_ready(fifo_m_ready),
    .o_m_data(fifo_m_data)
  );

  // loads the shift register; empty queue leaves the old byte to resend
  function automatic spiq_state_t load_tx(input spiq_state_t s, input logic [6:0] h);
    spiq_state_t t;
    t = s;
    if (s.tx_full)
    begin
      t.shift = s.tx_hold;
      t.tx_full = 1'b0;
      t.st.transmit_empty_flag = 1'b1;
    end // otherwise resend old shifter
    t.bitcnt = 4'h0;
    t.pend = 1'b0;
    t.div = h - 7'h01;
    t.xfer = SPIQ_XFER;
    return t;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    fifo_s_valid = 1'b0;
    fifo_s_data = r.shift;
    acc = !i_wait && !i_stop;
    frz = i_break && !i_break_clear_enable;
    lead_e = 1'b0;
    trail_e = 1'b0;
    chg = 1'b0;
    mfc = 1'b0;
    unique case ({r.sctrl.rate_select_hi, r.sctrl.rate_select_lo})
      2'h0: half = SPIQ_HALF_DIV2;
      2'h1: half = SPIQ_HALF_DIV8;
      2'h2: half = SPIQ_HALF_DIV32;
      2'h3: half = SPIQ_HALF_DIV128;
    endcase

    // register writes never touch flags directly
    if (acc && i_ctrl_wr)
    begin
      n.ctrl = i_ctrl_wdata;
    end
    if (acc && i_sctrl_wr)
    begin
      n.sctrl = i_sctrl_wdata;
    end

    // two-step clears, frozen during a protected break
    if (acc && !frz)
    begin
      if (i_data_rd && r.rf_arm)
      begin
        n.st.receive_full_flag = 1'b0;
        n.rf_arm = 1'b0;
      end
      if (i_data_rd && r.ovf_arm)
      begin
        n.st.overflow_flag = 1'b0;
        n.ovf_arm = 1'b0;
      end
      if (i_ctrl_wr && r.mf_arm)
      begin
        n.st.mode_fault_flag = 1'b0;
        n.mf_arm = 1'b0;
      end
      if (i_status_rd)
      begin
        n.rf_arm = r.st.receive_full_flag;
        n.ovf_arm = r.st.overflow_flag;
        n.mf_arm = r.st.mode_fault_flag;
      end
      if (i_data_wr)
      begin
        n.tx_hold = i_data_wdata;
        n.tx_full = 1'b1;
        n.st.transmit_empty_flag = 1'b0;
      end
    end // data writes while frozen are dropped

    ms = n.ctrl.master_select;
    n.sclk_d = sy_sclk;
    n.ss_d = sy_ss;

    if (!i_stop)
    begin
      // mode fault, detection gated by its enable
      mfc = r.ctrl.module_enable && r.sctrl.mode_fault_detect_enable &&
            ((ms && !sy_ss) || (!ms && r.xfer == SPIQ_XFER && sy_ss));
      if (mfc)
      begin
        n.st.mode_fault_flag = 1'b1;
        n.mf_arm = 1'b0;
        if (ms)
        begin
          n.ctrl.module_enable = 1'b0;
        end
      end

      // move buffered receive bytes into the data register
      if (fifo_m_valid && fifo_m_ready)
      begin
        n.rx_data = fifo_m_data;
        n.st.receive_full_flag = 1'b1;
      end

      en = n.ctrl.module_enable;
      if (ms)
      begin
        if (r.xfer == SPIQ_XFER)
        begin
          if (r.div == 7'h00)
          begin
            n.div = half - 7'h01;
            lead_e = (r.sclk_o == r.ctrl.cpol);
            trail_e = !lead_e;
            n.sclk_o = !r.sclk_o;
          end
          else
          begin
            n.div = r.div - 7'h01;
          end
        end
      end
      else
      begin
        // slave ignores clocks while deselected
        chg = (sy_sclk != r.sclk_d) && !sy_ss;
        lead_e = chg && (r.sclk_d == r.ctrl.cpol);
        trail_e = chg && (r.sclk_d != r.ctrl.cpol);
        if (r.xfer == SPIQ_IDLE && en)
        begin
          if ((!r.ctrl.cpha && r.ss_d && !sy_ss) || (r.ctrl.cpha && lead_e))
          begin
            n = load_tx(n, half);
          end
        end
      end

      // sample on one edge, shift the sampled bit in on the other
      if (n.xfer == SPIQ_XFER && (lead_e || trail_e))
      begin
        if (lead_e ^ n.ctrl.cpha)
        begin
          n.sbit = ms ? sy_miso : sy_mosi;
          n.pend = 1'b1;
          n.bitcnt = n.bitcnt + 4'h1;
        end
        else if (n.pend)
        begin
          n.shift = {n.shift[SPIQ_DATA_W-2:0], n.sbit};
          n.pend = 1'b0;
        end
      end

      if (n.xfer == SPIQ_XFER && n.bitcnt == SPIQ_BITS && (!n.pend || n.ctrl.cpha))
      begin
        if (n.pend)
        begin
          n.shift = {n.shift[SPIQ_DATA_W-2:0], n.sbit};
          n.pend = 1'b0;
        end
        n.xfer = SPIQ_IDLE;
        n.sclk_o = n.ctrl.cpol;
        fifo_s_data = n.shift;
        if (fifo_s_ready)
        begin
          fifo_s_valid = 1'b1;
        end
        else
        begin
          n.st.overflow_flag = 1'b1;
        end
      end

      // back-to-back master start from the queue
      if (ms && en && n.xfer == SPIQ_IDLE && n.tx_full)
      begin
        n = load_tx(n, half);
      end

      // partial reset while disabled
      if (!en)
      begin
        n.xfer = SPIQ_IDLE;
        n.shift = '0;
        n.bitcnt = 4'h0;
        n.pend = 1'b0;
        n.tx_full = 1'b0;
        n.div = 7'h00;
        n.sclk_o = n.ctrl.cpol;
        n.st.transmit_empty_flag = 1'b1;
      end
    end

    // pin ownership and drivers
    en = n.ctrl.module_enable;
    n.owns = en;
    n.sclk.out = n.sclk_o;
    n.sclk.oe_n = !(en && ms);
    n.mosi.out = n.ctrl.wired_or_mode ? 1'b0 : n.shift[SPIQ_DATA_W-1];
    n.mosi.oe_n = !(en && ms && (!n.ctrl.wired_or_mode || !n.shift[SPIQ_DATA_W-1]));
    n.miso.out = n.shift[SPIQ_DATA_W-1];
    n.miso.oe_n = !(en && !ms && !sy_ss);

    // level requests
    n.tx_irq = n.st.transmit_empty_flag && n.ctrl.transmit_irq_enable;
    n.rx_irq = (n.st.receive_full_flag && n.ctrl.receive_irq_enable && en) ||
               (n.ctrl.receive_irq_enable && n.sctrl.error_irq_enable &&
                (n.st.overflow_flag || n.st.mode_fault_flag));
    n.wake = i_wait && (n.tx_irq || n.rx_irq);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      r <= ST_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign o_ctrl = r.ctrl;
  assign o_sctrl = r.sctrl;
  assign o_status = r.st;
  assign o_rx_data = r.rx_data;
  assign o_tx_irq = r.tx_irq;
  assign o_rx_irq = r.rx_irq;
  assign o_wake = r.wake;
  assign o_spi_owns_pins = r.owns;
  assign o_sclk = r.sclk;
  assign o_mosi = r.mosi;
  assign o_miso = r.miso;
endmodule

// ===== spiq_top_asserts.sv
`timescale 1ns/1ns
module spiq_chk (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire spiq_pkg::spiq_ctrl_t o_ctrl,
  input wire spiq_pkg::spiq_sctrl_t o_sctrl,
  input wire spiq_pkg::spiq_status_t o_status,
  input wire logic o_tx_irq,
  input wire logic o_rx_irq,
  input wire logic o_spi_owns_pins,
  input wire spiq_pkg::spiq_pin_t o_mosi
);
  import spiq_pkg::*;
  logic tx_src;
  logic rx_src;
  logic err_src;
  assign tx_src = o_status.transmit_empty_flag & o_ctrl.transmit_irq_enable;
  assign rx_src = o_status.receive_full_flag & o_ctrl.receive_irq_enable & o_ctrl.module_enable;
  assign err_src = (o_status.overflow_flag | o_status.mode_fault_flag) & o_ctrl.receive_irq_enable
    & o_sctrl.error_irq_enable;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  a_tx_irq_on: assert property (tx_src [*2] |-> o_tx_irq)
    else $error("tx request missing");
  a_rx_irq_on: assert property (rx_src [*2] |-> o_rx_irq)
    else $error("rx request missing");
  a_err_irq_on: assert property (err_src [*2] |-> o_rx_irq)
    else $error("error request missing");
  a_rx_irq_off: assert property ((!rx_src && !err_src) [*2] |-> !o_rx_irq)
    else $error("rx request without cause");
  a_fault_blocked: assert property (!o_sctrl.mode_fault_detect_enable && !o_status.mode_fault_flag
    |=> !o_status.mode_fault_flag)
    else $error("mode fault set while detection off");
  a_off_empty: assert property (!o_ctrl.module_enable |-> o_status.transmit_empty_flag)
    else $error("transmit empty low while disabled");
  a_off_pins: assert property (!o_ctrl.module_enable |-> !o_spi_owns_pins && o_mosi.oe_n)
    else $error("pins held while disabled");
  a_fault_drops_en: assert property ($rose(o_status.mode_fault_flag) && o_ctrl.master_select
    |-> ##[0:1] !o_ctrl.module_enable)
    else $error("master fault left module enabled");
endmodule
bind spiq_top spiq_chk i_spiq_chk (.i_clk, .i_rstn, .o_ctrl, .o_sctrl, .o_status, .o_tx_irq, .o_rx_irq,
  .o_spi_owns_pins, .o_mosi);

// ===== tb.sv
`timescale 1ns/1ns
module tb;
  import spiq_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ctrl_wr = 1'b0;
  spiq_ctrl_t i_ctrl_wdata = 7'h00;
  logic i_sctrl_wr = 1'b0;
  spiq_sctrl_t i_sctrl_wdata = 4'h0;
  logic i_status_rd = 1'b0;
  logic i_data_rd = 1'b0;
  logic i_data_wr = 1'b0;
  logic [7:0] i_data_wdata = 8'h00;
  logic i_wait = 1'b0;
  logic i_stop = 1'b0;
  logic i_break = 1'b0;
  logic i_break_clear_enable = 1'b0;
  logic i_ss_n_pin = 1'b1;
  spiq_ctrl_t o_ctrl;
  spiq_sctrl_t o_sctrl;
  spiq_status_t o_status;
  logic [7:0] o_rx_data;
  logic o_tx_irq;
  logic o_rx_irq;
  logic o_wake;
  logic o_spi_owns_pins;
  spiq_pin_t o_sclk;
  spiq_pin_t o_mosi;
  spiq_pin_t o_miso;
  logic sclk_w;
  logic mosi_w;
  logic miso_w;
  logic [31:0] rs = 32'h00000027;
  logic [31:0] r;
  logic [15:0] ptx = 16'h0000;
  logic [15:0] prx;
  int failures = 0;
  int tests_run = 0;
  int k;
  // idle clock low, data line pulled up
  assign sclk_w = o_sclk.oe_n ? 1'b0 : o_sclk.out;
  assign mosi_w = o_mosi.oe_n ? 1'b1 : o_mosi.out;
  always #20 i_clk = ~i_clk;
  spiq_top i_spiq_top (.i_clk, .i_rstn, .i_ctrl_wr, .i_ctrl_wdata, .i_sctrl_wr, .i_sctrl_wdata,
    .i_status_rd, .i_data_rd, .i_data_wr, .i_data_wdata, .i_wait, .i_stop, .i_break,
    .i_break_clear_enable, .i_sclk_pin(sclk_w), .i_ss_n_pin, .i_mosi_pin(mosi_w), .i_miso_pin(miso_w),
    .o_ctrl, .o_sctrl, .o_status, .o_rx_data, .o_tx_irq, .o_rx_irq, .o_wake, .o_spi_owns_pins,
    .o_sclk, .o_mosi, .o_miso);
  spiq_slave_model i_spiq_slave_model (.i_sclk(sclk_w), .i_mosi(mosi_w),
    .i_sel(o_spi_owns_pins & o_ctrl.master_select), .i_tx(ptx), .o_miso(miso_w), .o_rx(prx));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick;
    s = 1'b0;
    tick;
  endtask
  task automatic wr_ctrl(input spiq_ctrl_t v);
    i_ctrl_wdata = v;
    pulse(i_ctrl_wr);
  endtask
  task automatic wait_st(input int b);
    int n;
    n = 0;
    while (o_status[b] !== 1'b1 && n < 5000)
    begin
      tick;
      n++;
    end
    if (n == 5000)
    begin
      failures++;
      final_report;
    end
  endtask
  // software writes only while transmit empty is high
  task automatic send(input logic [7:0] d);
    wait_st(0);
    i_data_wdata = d;
    pulse(i_data_wr);
    tick(3);
  endtask
  task automatic pop;
    pulse(i_status_rd);
    pulse(i_data_rd);
  endtask
  initial
  begin
    tick(12);
    check("reset ctrl", {o_ctrl, o_sctrl, o_status}, 15'h2801);
    check("reset outs", {o_tx_irq, o_rx_irq, o_wake, o_spi_owns_pins, o_sclk, o_mosi, o_miso}, 10'h015);
    i_rstn = 1'b1;
    tick;
    $display("test reset finished");
    i_sctrl_wdata = 4'hA;
    pulse(i_sctrl_wr);
    wr_ctrl(7'h6F);
    check("tx irq", o_tx_irq, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      r = rnd();
      ptx = r[15:0];
      send(r[23:16]);
      send(r[31:24]);
      check("te queued", o_status.transmit_empty_flag, 1'b0);
      wait_st(3);
      tick(2);
      check("te back", o_status.transmit_empty_flag, 1'b1);
      check("rx first", {o_rx_data, o_rx_irq}, {ptx[15:8], 1'b1});
      pop;
      check("rf clear", o_status.receive_full_flag, 1'b0);
      wait_st(3);
      check("rx second", o_rx_data, ptx[7:0]);
      check("mosi bytes", prx, {r[23:16], r[31:24]});
      pop;
    end
    $display("test queue finished");
    send(8'h3C);
    wait_st(3);
    pulse(i_status_rd);
    i_break = 1'b1;
    pulse(i_data_rd);
    check("rf hold", o_status.receive_full_flag, 1'b1);
    i_data_wdata = 8'hC3;
    pulse(i_data_wr);
    check("te hold", o_status.transmit_empty_flag, 1'b1);
    i_break = 1'b0;
    pulse(i_data_rd);
    check("rf second step", o_status.receive_full_flag, 1'b0);
    send(8'h5A);
    wait_st(3);
    i_break = 1'b1;
    i_break_clear_enable = 1'b1;
    pop;
    i_break = 1'b0;
    tick;
    check("rf kept", o_status.receive_full_flag, 1'b0);
    i_break_clear_enable = 1'b0;
    $display("test break finished");
    send(8'h81);
    wait_st(3);
    wr_ctrl(7'h6D);
    check("off regs", {o_ctrl, o_sctrl, o_status}, 15'h6DA9);
    check("off outs", {o_spi_owns_pins, o_rx_irq, o_tx_irq}, 3'h1);
    pop;
    wr_ctrl(7'h6F);
    for (int i = 0; i < 34; i++)
    begin
      r = rnd();
      send(r[7:0]);
    end
    wait_st(2);
    k = 0;
    while (o_status.receive_full_flag === 1'b1 && k < 40)
    begin
      pop;
      tick(4);
      k++;
    end
    check("held bytes", k[15:0], 16'h0021);
    check("drained", o_status, 4'h1);
    $display("test overflow finished");
    i_sctrl_wdata = 4'hE;
    pulse(i_sctrl_wr);
    i_ss_n_pin = 1'b0;
    wait_st(1);
    tick(2);
    check("fault", {o_ctrl.module_enable, o_status, o_rx_irq}, 6'h07);
    i_ss_n_pin = 1'b1;
    tick(8);
    pulse(i_status_rd);
    wr_ctrl(7'h6F);
    check("fault clear", o_status.mode_fault_flag, 1'b0);
    i_sctrl_wdata = 4'hA;
    pulse(i_sctrl_wr);
    i_ss_n_pin = 1'b0;
    tick(20);
    check("no fault", {o_ctrl.module_enable, o_status.mode_fault_flag}, 2'h2);
    wr_ctrl(7'h4B);
    tick(6);
    check("slave drives", o_miso.oe_n, 1'b0);
    i_ss_n_pin = 1'b1;
    tick(6);
    check("slave released", o_miso.oe_n, 1'b1);
    wr_ctrl(7'h6F);
    $display("test fault finished");
    i_wait = 1'b1;
    wr_ctrl(7'h6D);
    check("wait", {o_ctrl, o_wake}, 8'hDF);
    i_wait = 1'b0;
    i_stop = 1'b1;
    i_data_wdata = 8'h99;
    pulse(i_data_wr);
    check("stop", o_status.transmit_empty_flag, 1'b1);
    i_stop = 1'b0;
    tick(300);
    check("stop no transfer", o_status.receive_full_flag, 1'b0);
    $display("test low_power finished");
    final_report;
  end
endmodule
